// ==== testbench/cdes_board_model.sv ====
// Board side: drives the shared control pin and a free-running external
// reference. Assumes the bench sets pin_level between falling edges.
`timescale 1ns/10ps
module cdes_board_model
#(
  parameter int EXT_HALF = 6
)
(
  input  wire logic clk,
  input  wire logic pin_level,
  output logic      shared_control_pin,
  output logic      external_reference_input
);
  int half_cnt = 0;
  initial
  begin
    shared_control_pin = 1'b1;
    external_reference_input = 1'b0;
  end
  // Oscillator runs free, so the reference never stands still
  always @(negedge clk)
  begin
    shared_control_pin <= pin_level;
    half_cnt <= (half_cnt == EXT_HALF - 1) ? 0 : half_cnt + 1;
    if (half_cnt == EXT_HALF - 1)
      external_reference_input <= ~external_reference_input;
  end
endmodule

// ==== testbench/cdes_top_assertions.sv ====
// Concurrent checks on the pins of the divider sequencer top.
// Assumes configuration inputs stay stable between power cycles.
`timescale 1ns/10ps
module cdes_top_assertions
#(
  parameter int LONG_LIMIT = 2400,
  parameter int REF_LIMIT  = 64
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic gate_in,
  input wire logic shared_control_pin,
  input wire logic pin_function_bit,
  input wire logic reference_pin_disable_bit,
  input wire logic divided_clock_pin,
  input wire logic divided_clock_oe,
  input wire logic reference_clock_pin,
  input wire logic reference_clock_oe,
  input wire logic oscillator_enable
);
  // ----------------------------------------------------------------
  // Stall counters, saturating so a long stall never wraps to zero
  // ----------------------------------------------------------------
  logic [11:0] gate_q;
  logic [11:0] low_q;
  logic [11:0] pd_q;
  logic [11:0] ref_q;
  logic        ref_prev_q;
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst || gate_in) gate_q <= 12'h000;
    else if (gate_q != 12'hfff) gate_q <= gate_q + 12'h001;
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst || divided_clock_pin || !gate_in || !divided_clock_oe) low_q <= 12'h000;
    else if (low_q != 12'hfff) low_q <= low_q + 12'h001;
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst || shared_control_pin || !pin_function_bit) pd_q <= 12'h000;
    else if (pd_q != 12'hfff) pd_q <= pd_q + 12'h001;
  // Plain delay register keeps the stall counter free of sampled-value calls
  always_ff @(posedge clk)
    ref_prev_q <= reference_clock_pin;
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst || !reference_clock_oe || reference_clock_pin != ref_prev_q)
      ref_q <= 12'h000;
    else if (ref_q != 12'hfff) ref_q <= ref_q + 12'h001;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  a_gate_holds_low: assert property (gate_q >= LONG_LIMIT |-> !divided_clock_pin)
    else $error("divided pin high while gated off");
  a_low_phase_bound: assert property (low_q < LONG_LIMIT)
    else $error("divided pin low too long while enabled");
  a_pd_all_off: assert property (pd_q >= LONG_LIMIT |->
    !divided_clock_oe && !reference_clock_oe && !oscillator_enable)
    else $error("power-down did not complete");
  a_osc_on_release: assert property ($rose(shared_control_pin) && pin_function_bit
    |-> ##[1:6] oscillator_enable)
    else $error("oscillator not enabled on release");
  a_ref_disabled: assert property (reference_pin_disable_bit |-> !reference_clock_oe)
    else $error("reference pin driven while disabled");
  a_ref_toggles: assert property (ref_q < REF_LIMIT)
    else $error("reference pin stalled while driven");
  a_div_after_ref: assert property ($rose(divided_clock_oe) && !reference_pin_disable_bit
    |-> $past(reference_clock_oe))
    else $error("divided pin enabled before reference pin");
  a_tri_when_low: assert property ($fell(divided_clock_oe) |-> !$past(divided_clock_pin))
    else $error("divided pin released while high");
  a_osc_off_last: assert property ($fell(oscillator_enable)
    |-> !divided_clock_oe && !reference_clock_oe)
    else $error("oscillator stopped before outputs released");
  c_power_down: cover property ($fell(oscillator_enable));
  c_power_up: cover property ($rose(divided_clock_oe));
  c_gate_high: cover property ($fell(gate_in) && divided_clock_pin);
endmodule

// ==== testbench/cdes_top_tb.sv ====
// Self-checking bench for the divider sequencer top.
// Assumes a 50 MHz clock; inputs change on falling edges.
`timescale 1ns/10ps
`define CHK(nm, e, g) \
  check_count++; \
  if ((g) !== (e)) \
  begin \
    $display("mismatch %s expected %0d seen %0d", nm, e, g); \
    mismatches++; \
  end
module cdes_top_tb;
  import cdes_pkg::*;
  logic       clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic       gate_in = 1'b1;
  logic       pin_level = 1'b1;
  logic [8:0] divider_value;
  logic       pin_function_bit, reference_pin_disable_bit, prescaler_bypass_bit;
  logic       prescale_select_bit, divide_by_one_bit, source_bit;
  logic       shared_control_pin, external_reference_input;
  logic       divided_clock_pin, divided_clock_oe, reference_clock_pin;
  logic       reference_clock_oe, oscillator_enable;
  int         mismatches = 0;
  int         check_count = 0;
  int         n, m, p;
  cdes_top u_cdes_top (.clk, .sys_rst, .gate_in, .shared_control_pin,
    .external_reference_input, .divider_value, .pin_function_bit,
    .reference_pin_disable_bit, .prescaler_bypass_bit, .prescale_select_bit,
    .divide_by_one_bit, .source_bit, .divided_clock_pin, .divided_clock_oe,
    .reference_clock_pin, .reference_clock_oe, .oscillator_enable);
  cdes_board_model u_cdes_board_model (.clk, .pin_level, .shared_control_pin,
    .external_reference_input);
  always #10 clk = ~clk;
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  function automatic logic sig(input int s);
    case (s)
      0: sig = divided_clock_pin;
      1: sig = reference_clock_pin;
      2: sig = divided_clock_oe;
      3: sig = reference_clock_oe;
      default: sig = oscillator_enable;
    endcase
  endfunction
  task automatic wait_for(input int s, input logic v, input int lim, output int c);
    c = 0;
    while (sig(s) !== v)
    begin
      @(negedge clk);
      c++;
      if (c > lim)
      begin
        $display("mismatch wait %0d expected %0d seen %0d", s, v, sig(s));
        mismatches++;
        complete_run();
      end
    end
  endtask
  // Period in clocks between two rising edges
  task automatic measure(input int s, output int per);
    int a, b;
    wait_for(s, 0, 3000, a);
    wait_for(s, 1, 3000, a);
    wait_for(s, 0, 3000, a);
    wait_for(s, 1, 3000, b);
    per = a + b;
  endtask
  task automatic cfg(input logic [8:0] c, input logic pf, rd, bp, ps, d1, sr);
    divider_value = c;
    pin_function_bit = pf;
    reference_pin_disable_bit = rd;
    prescaler_bypass_bit = bp;
    prescale_select_bit = ps;
    divide_by_one_bit = d1;
    source_bit = sr;
  endtask
  task automatic do_reset();
    sys_rst = 1'b1;
    repeat (4) @(negedge clk);
    sys_rst = 1'b0;
  endtask
  task automatic power_cycle(input logic [8:0] c, input logic bp, ps, d1, sr);
    @(negedge clk);
    pin_level = 1'b0;
    wait_for(4, 0, 3000, n);
    `CHK("div oe off", 1'b0, divided_clock_oe)
    `CHK("ref oe off", 1'b0, reference_clock_oe)
    // Stay down past the checker's power-down window
    repeat (640) @(negedge clk);
    `CHK("osc held off", 1'b0, oscillator_enable)
    cfg(c, 1'b1, 1'b0, bp, ps, d1, sr);
    pin_level = 1'b1;
    wait_for(4, 1, 20, n);
    // An external source stretches the wait to 257 slow reference rises
    wait_for(3, 1, 3500, n);
    `CHK("stab wait", 1, n >= 2048)
    wait_for(2, 1, 8, m);
    `CHK("oe order", 1, m)
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_bring_up();
    do_reset();
    `CHK("osc en", 1'b1, oscillator_enable)
    `CHK("div oe", 1'b0, divided_clock_oe)
    wait_for(2, 1, 3000, n);
    `CHK("ref disabled", 1'b0, reference_clock_oe)
    measure(0, p);
    `CHK("div period", 10, p)
    $display("test bring_up done");
  endtask
  task automatic t_divisors();
    logic [8:0] codes[6] = '{9'h000, 9'h1ff, 9'h000, 9'h000, 9'h005, 9'h000};
    logic [3:0] modes[6] = '{4'h1, 4'h1, 4'h2, 4'h0, 4'h4, 4'h8};
    int dexp[6] = '{4, 1026, 8, 16, 2, 24};
    int rexp[6] = '{2, 2, 4, 8, 2, 12};
    for (int i = 0; i < 6; i++)
    begin
      power_cycle(codes[i], modes[i][0], modes[i][1], modes[i][2], modes[i][3]);
      measure(0, p);
      `CHK("div period", dexp[i], p)
      measure(1, p);
      `CHK("ref period", rexp[i], p)
    end
    $display("test divisors done");
  endtask
  task automatic t_gate();
    power_cycle(9'h003, 1'b1, 1'b0, 1'b0, 1'b0);
    wait_for(0, 1, 20, n);
    gate_in = 1'b0;
    wait_for(0, 0, 20, n);
    `CHK("last high width", 6, n)
    m = 0;
    p = 0;
    // Long enough to reach the checker's gated-off window
    repeat (640)
    begin
      @(negedge clk);
      m += divided_clock_pin;
      p += reference_clock_pin;
    end
    `CHK("gated highs", 0, m)
    `CHK("ref running", 1, p > 0)
    `CHK("oe kept", 1'b1, divided_clock_oe)
    gate_in = 1'b1;
    wait_for(0, 1, 12, n);
    `CHK("first edge", 1, n <= 8 && n >= 3)
    measure(0, p);
    `CHK("period after", 10, p)
    $display("test gate done");
  endtask
  task automatic t_select();
    cfg(9'h000, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
    do_reset();
    wait_for(2, 1, 3000, n);
    measure(1, p);
    `CHK("internal ref", 2, p)
    pin_level = 1'b0;
    repeat (40) @(negedge clk);
    `CHK("no power-down", 1'b1, oscillator_enable)
    measure(1, p);
    `CHK("external ref", 12, p)
    measure(0, p);
    `CHK("external div", 24, p)
    pin_level = 1'b1;
    repeat (40) @(negedge clk);
    measure(1, p);
    `CHK("back internal", 2, p)
    $display("test select done");
  endtask
  initial
  begin
    cfg(9'h003, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    t_bring_up();
    t_divisors();
    t_gate();
    t_select();
    complete_run();
  end
endmodule
bind cdes_top cdes_top_assertions #(.LONG_LIMIT(600)) u_cdes_top_assertions (.clk, .sys_rst, .gate_in,
  .shared_control_pin, .pin_function_bit, .reference_pin_disable_bit,
  .divided_clock_pin, .divided_clock_oe, .reference_clock_pin,
  .reference_clock_oe, .oscillator_enable);

// ==== verilog/cdes_divider.sv ====
// Programmable divide-by-N counter stepped by master clock rising edges.
// Assumes tick is a one-cycle pulse and mclk the master clock level.
`timescale 1ns/10ps
module cdes_divider
  import cdes_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       tick,
  input  wire logic       mclk,
  input  wire logic       clear,
  input  wire logic       bypass,
  input  wire logic [8:0] code,
  output logic            level_q
);

  logic [9:0] cnt_q;
  logic       idle_q;
  logic [9:0] divisor;
  logic [9:0] half;
  logic [9:0] cnt_d;

  assign divisor = {1'b0, code} + DIVISOR_OFFSET;
  assign half    = (divisor + 10'h001) >> 1;
  assign cnt_d   = (idle_q || cnt_q == divisor - 10'h001) ? 10'h000 : cnt_q + 10'h001;

  // ----------------------------------------------------------------
  // Counter; cleared state restarts with a high phase on next tick
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cnt_q   <= 10'h000;
      idle_q  <= 1'b1;
      level_q <= 1'b0;
    end
    else if (clear)
    begin
      cnt_q   <= 10'h000;
      idle_q  <= 1'b1;
      level_q <= 1'b0;
    end
    else if (bypass)
    begin
      idle_q  <= 1'b1;
      level_q <= mclk;
    end
    else if (tick)
    begin
      cnt_q   <= cnt_d;
      idle_q  <= 1'b0;
      level_q <= (cnt_d < half);
    end
  end

endmodule

// ==== verilog/cdes_pkg.sv ====
// Constants for the clock divider enable sequencer: configuration layout,
// values after reset, sequencing states and counts.
// Assumes a single 50 MHz system clock drives every flip-flop of the block.
package cdes_pkg;

  // ----------------------------------------------------------------
  // Configuration word layout (mode word)
  // ----------------------------------------------------------------
  localparam int MODE_SRC_POS    = 0;
  localparam int MODE_DIVIDE_BY_ONE_BIT_POS   = 1;
  localparam int MODE_BYPASS_POS = 2;
  localparam int MODE_PSEL_POS   = 3;
  localparam int MODE_PFUNC_POS  = 4;
  localparam int MODE_REFDIS_POS = 5;

  // ----------------------------------------------------------------
  // Values after reset and during stabilisation
  // ----------------------------------------------------------------
  localparam logic [8:0] MODE_RESET       = 9'h034;
  localparam logic [8:0] DIVIDER_RESET    = 9'h000;
  localparam logic [8:0] DIVIDER_MAX      = 9'h1ff;
  localparam logic [9:0] DIVISOR_OFFSET   = 10'h002;
  localparam logic [8:0] STAB_MCLK_CYCLES = 9'h100;

  // ----------------------------------------------------------------
  // Sequencer states, Gray coded around the power cycle
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CDES_PU_WAIT = 3'h0,
    CDES_PU_REF  = 3'h1,
    CDES_RUN     = 3'h3,
    CDES_PD_GATE = 3'h2,
    CDES_PD_TRI  = 3'h6,
    CDES_PD_OFF  = 3'h4
  } cdes_state_t;

endpackage

// ==== verilog/cdes_sync.sv ====
// Two-stage level synchroniser for asynchronous control pins.
// Assumes the destination clock is the block clock.
`timescale 1ns/10ps
module cdes_sync
  import cdes_pkg::*;
#(
  parameter int W = 1
)
(
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      meta_q   <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

// ==== verilog/cdes_top.sv ====
// Output gating, reference switching and power sequencing of a
// programmable oscillator, modelled on the block clock.
// Assumes the internal oscillator is a toggle at half the block clock and
// that the external reference input is synchronous; gate and control pins pass a synchroniser.
`timescale 1ns/10ps

// Overview of operation
// - Pin function bit picks select or power-down
// - Disable bit tristates reference pin, else drives
// - Gate ignores reference pin; power-down disables it
// - Divide master clock by field plus two
// - Gate sampled on master clock rising edges
// - First output edge one to two periods
// - Gating never shortens an output pulse
// - Gate falls while high: finish pulse
// - Missed setup while low: one extra pulse
// - Divide-by-one: one or two extra pulses
// - Internal-to-external detected on internal falling edge
// - Hold low half period, then external low
// - External-to-internal is level triggered
// - Hold low until internal fall, then pass
// - Divided pin follows same glitch-free switching
// - Internal clock is oscillator over prescale
// - Power-down request low starts the sequence
// - Gate off, clear counters, then tristate output
// - Stop master clock, tristate reference, oscillator off
// - Power-up: max values, wait 256, restore
// - Gated off: oscillator runs, counters held
// - Select mode: high internal, low external
// - Bypass skips prescaler, else divide 4/2
// - Divide-by-one routes master clock straight out
module cdes_top
  import cdes_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       gate_in,
  input  wire logic       shared_control_pin,
  input  wire logic       external_reference_input,
  input  wire logic [8:0] divider_value,
  input  wire logic       pin_function_bit,
  input  wire logic       reference_pin_disable_bit,
  input  wire logic       prescaler_bypass_bit,
  input  wire logic       prescale_select_bit,
  input  wire logic       divide_by_one_bit,
  input  wire logic       source_bit,
  output logic            divided_clock_pin,
  output logic            divided_clock_oe,
  output logic            reference_clock_pin,
  output logic            reference_clock_oe,
  output logic            oscillator_enable
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  cdes_state_t state_q;
  logic [1:0]  sync_out;
  logic        gate_sync;
  logic        ctl_sync;
  logic [8:0]  div_cfg_q;
  logic [8:0]  mode_cfg_q;
  logic        pfunc;
  logic        pd_req;
  logic        want_ext;
  logic [8:0]  eff_div;
  logic        eff_divide_by_one_bit;
  logic        eff_bypass;
  logic        eff_psel;
  logic        osc_q;
  logic [1:0]  pre_cnt_q;
  logic        int_clk_d;
  logic        int_q;
  logic        int_prev_q;
  logic        int_fall;
  logic        int_rise;
  logic        ext_q;
  logic        use_ext_q;
  logic        hold_q;
  logic        wait_half_q;
  logic        mclk_stop;
  logic        mclk_d;
  logic        mclk_q;
  logic        mclk_prev_q;
  logic        mclk_rise;
  logic        gate_en_q;
  logic        run_q;
  logic        div_level;
  logic [8:0]  stab_cnt_q;

  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  cdes_sync #(.W(2)) u_sync (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .async_in ({shared_control_pin, gate_in}),
    .sync_out (sync_out)
  );

  assign gate_sync = sync_out[0];
  assign ctl_sync  = sync_out[1];

  // ----------------------------------------------------------------
  // Shared pin function and effective settings
  // ----------------------------------------------------------------
  assign pfunc    = mode_cfg_q[MODE_PFUNC_POS];
  assign pd_req   = pfunc & ~ctl_sync;
  assign want_ext = pfunc ? mode_cfg_q[MODE_SRC_POS] : ~ctl_sync;

  // Stabilisation runs at the slowest settings so the outputs stay quiet
  assign eff_div    = (state_q == CDES_PU_WAIT) ? DIVIDER_MAX : div_cfg_q;
  assign eff_divide_by_one_bit   = (state_q != CDES_PU_WAIT) & mode_cfg_q[MODE_DIVIDE_BY_ONE_BIT_POS];
  assign eff_bypass = (state_q != CDES_PU_WAIT) & mode_cfg_q[MODE_BYPASS_POS];
  assign eff_psel   = (state_q != CDES_PU_WAIT) & mode_cfg_q[MODE_PSEL_POS];

  // ----------------------------------------------------------------
  // Configuration restore
  // ----------------------------------------------------------------
  // Settings only change at the end of stabilisation, never on the fly
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      div_cfg_q  <= DIVIDER_RESET;
      mode_cfg_q <= MODE_RESET;
    end
    else if (state_q == CDES_PU_WAIT && mclk_rise && stab_cnt_q == STAB_MCLK_CYCLES)
    begin
      div_cfg_q  <= divider_value;
      mode_cfg_q <= {3'h0, reference_pin_disable_bit, pin_function_bit,
                     prescale_select_bit, prescaler_bypass_bit,
                     divide_by_one_bit, source_bit};
    end
  end

  // ----------------------------------------------------------------
  // Internal oscillator and prescaler
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      osc_q     <= 1'b0;
      pre_cnt_q <= 2'h0;
    end
    else if (oscillator_enable)
    begin
      osc_q <= ~osc_q;
      if (!osc_q)
      begin
        pre_cnt_q <= pre_cnt_q + 2'h1;
      end
    end
  end

  always_comb
  begin
    if (eff_divide_by_one_bit || eff_bypass)
    begin
      int_clk_d = osc_q;
    end
    else
    begin
      int_clk_d = eff_psel ? pre_cnt_q[0] : pre_cnt_q[1];
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      int_q      <= 1'b0;
      int_prev_q <= 1'b0;
      ext_q      <= 1'b0;
    end
    else
    begin
      int_q      <= int_clk_d;
      int_prev_q <= int_q;
      ext_q      <= oscillator_enable & external_reference_input;
    end
  end

  assign int_fall = int_prev_q & ~int_q;
  assign int_rise = ~int_prev_q & int_q;

  // ----------------------------------------------------------------
  // Glitch-free reference switch
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      use_ext_q   <= 1'b0;
      hold_q      <= 1'b0;
      wait_half_q <= 1'b0;
    end
    else if (!use_ext_q)
    begin
      if (!hold_q)
      begin
        if (want_ext && int_fall)
        begin
          hold_q      <= 1'b1;
          wait_half_q <= 1'b1;
        end
      end
      else if (wait_half_q)
      begin
        if (int_rise)
        begin
          wait_half_q <= 1'b0;
        end
      end
      else if (!ext_q)
      begin
        use_ext_q <= 1'b1;
        hold_q    <= 1'b0;
      end
    end
    else
    begin
      if (!hold_q)
      begin
        // Level, not edge: works even with no external clock present
        if (!want_ext && !ext_q)
        begin
          hold_q <= 1'b1;
        end
      end
      else if (int_fall)
      begin
        use_ext_q <= 1'b0;
        hold_q    <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Master clock
  // ----------------------------------------------------------------
  assign mclk_stop = (state_q == CDES_PD_TRI) || (state_q == CDES_PD_OFF);

  always_comb
  begin
    if (mclk_stop || hold_q)
    begin
      mclk_d = 1'b0;
    end
    else
    begin
      mclk_d = use_ext_q ? ext_q : int_q;
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      mclk_q      <= 1'b0;
      mclk_prev_q <= 1'b0;
    end
    else
    begin
      mclk_q      <= mclk_d;
      mclk_prev_q <= mclk_q;
    end
  end

  assign mclk_rise = mclk_q & ~mclk_prev_q;

  // ----------------------------------------------------------------
  // Output gate and divider
  // ----------------------------------------------------------------
  // A late gate change misses this edge and waits for the next one
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      gate_en_q <= 1'b0;
    end
    else if (mclk_rise)
    begin
      gate_en_q <= gate_sync & (state_q == CDES_RUN);
    end
  end

  // Run stays up until the current high phase ends
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      run_q <= 1'b0;
    end
    else
    begin
      run_q <= gate_en_q | (run_q & div_level);
    end
  end

  // Counters held while gated; the master clock keeps running
  cdes_divider u_div (
    .clk     (clk),
    .sys_rst (sys_rst),
    .tick    (mclk_rise),
    .mclk    (mclk_q),
    .clear   (~run_q),
    .bypass  (eff_divide_by_one_bit),
    .code    (eff_div),
    .level_q (div_level)
  );

  // ----------------------------------------------------------------
  // Enabling sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_q    <= CDES_PU_WAIT;
      stab_cnt_q <= 9'h000;
    end
    else
    begin
      case (state_q)
        CDES_PU_WAIT:
        begin
          if (mclk_rise)
          begin
            stab_cnt_q <= stab_cnt_q + 9'h001;
            if (stab_cnt_q == STAB_MCLK_CYCLES)
            begin
              state_q <= CDES_PU_REF;
            end
          end
        end
        CDES_PU_REF:
        begin
          state_q <= CDES_RUN;
        end
        CDES_RUN:
        begin
          if (pd_req)
          begin
            state_q <= CDES_PD_GATE;
          end
        end
        CDES_PD_GATE:
        begin
          if (!gate_en_q && !run_q && !divided_clock_pin)
          begin
            state_q <= CDES_PD_TRI;
          end
        end
        CDES_PD_TRI:
        begin
          state_q <= CDES_PD_OFF;
        end
        CDES_PD_OFF:
        begin
          if (!pd_req)
          begin
            state_q    <= CDES_PU_WAIT;
            stab_cnt_q <= 9'h000;
          end
        end
        default:
        begin
          state_q <= CDES_PU_WAIT;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Output pins
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      divided_clock_pin   <= 1'b0;
      divided_clock_oe    <= 1'b0;
      reference_clock_pin <= 1'b0;
      reference_clock_oe  <= 1'b0;
      oscillator_enable   <= 1'b1;
    end
    else
    begin
      divided_clock_pin   <= div_level & run_q;
      divided_clock_oe    <= (state_q == CDES_RUN) || (state_q == CDES_PD_GATE);
      reference_clock_pin <= mclk_q;
      // The gate has no say here; only the disable bit and power state
      reference_clock_oe  <= ~mode_cfg_q[MODE_REFDIS_POS] &
                             ((state_q == CDES_PU_REF) || (state_q == CDES_RUN) ||
                              (state_q == CDES_PD_GATE));
      oscillator_enable   <= (state_q != CDES_PD_OFF) || !pd_req;
    end
  end

endmodule
